// [shared/msi_cfg.svh]
`ifndef MSI_CFG_SVH
`define MSI_CFG_SVH

// two-wire bus address of the diagnostic memory, direction bit excluded
`define MSI_DEV_ADDR      7'h51
// number of byte-wide words in the diagnostic memory
`define MSI_MEM_DEPTH     256
// bits in one transferred byte
`define MSI_BYTE_BITS     4'h8
// reset value of every stored byte
`define MSI_BYTE_RESET    8'h00
// calibration constants for an externally calibrated module
`define MSI_CAL_LO        8'h38
`define MSI_CAL_HI        8'h5F
// first byte of the live converter readings, ten bytes, high byte first
`define MSI_DIAG_BASE     8'h60
`define MSI_DIAG_BYTES    10
// window that the host may write; everything else is write protected
`define MSI_USER_LO       8'h80
`define MSI_USER_HI       8'hF7

`endif

// [shared/msi_pkg.sv]
package msi_pkg;
`include "msi_cfg.svh"

	// serial protocol states
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_WORD,
		S_WDATA,
		S_ACK,
		S_RDATA,
		S_RACK,
		S_RNEXT
	} msi_bus_state_type;

	// raw converter readings, in memory order
	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] vcc;
		logic [15:0] bias;
		logic [15:0] tx_pwr;
		logic [15:0] rx_pwr;
	} msi_diag_type;

	// one byte write request
	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} msi_wr_type;

	// storage of the memory module
	typedef struct packed {
		logic [`MSI_MEM_DEPTH-1:0][7:0] bytes;
	} msi_mem_state_type;

	// whole state of the top module
	typedef struct packed {
		logic              scl_s1;
		logic              scl_s2;
		logic              scl_s3;
		logic              sda_s1;
		logic              sda_s2;
		logic              sda_s3;
		logic              txd_s1;
		logic              txd_s2;
		logic              tx_on;
		logic              fault;
		logic              optical_input_lost;
		msi_bus_state_type state;
		msi_bus_state_type after;
		logic [3:0]        cnt;
		logic [7:0]        shift;
		logic [7:0]        ptr;
		logic              sda_oe;
	} msi_top_state_type;

endpackage

// [src/msi_mem.sv]
`timescale 1ns/1ns
`default_nettype none
`include "msi_cfg.svh"

module msi_mem (
	input  wire logic                 clk,        // system clock
	input  wire logic                 rst,        // async reset, active high
	input  wire logic                 ce,         // clock enable
	input  wire msi_pkg::msi_wr_type  host_wr,    // write from the serial host
	input  wire msi_pkg::msi_wr_type  factory_wr, // manufacture load, ignores protection
	input  wire msi_pkg::msi_diag_type diag,      // live raw readings
	input  wire logic [7:0]           rd_addr,    // read index
	output logic      [7:0]           rd_data     // byte at read index
);
	import msi_pkg::*;

	msi_mem_state_type q;       // registered storage
	msi_mem_state_type d;       // next storage
	logic              host_ok; // host write falls in the open window
	logic [7:0]        rd_data_at_host; // old byte at the host address

	// write protection check
	assign host_ok = (host_wr.addr >= `MSI_USER_LO) && (host_wr.addr <= `MSI_USER_HI);

	// next value of storage
	always_comb begin
		d = q;
		// factory load of calibration and thresholds
		if (factory_wr.en) begin
			d.bytes[factory_wr.addr] = factory_wr.data; // RULE_12
		end
		// host writes land only outside protected segments
		if (host_wr.en && host_ok) begin
			d.bytes[host_wr.addr] = host_wr.data; // RULE_07
		end
		// readings refreshed every cycle that ce is high, raw converter codes
		for (int i = 0; i < `MSI_DIAG_BYTES; i++) begin
			d.bytes[`MSI_DIAG_BASE + 8'(i)] = diag[79 - 8 * i -: 8]; // RULE_11 RULE_13
		end
	end

	// storage registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	// read mux over stored bytes
	assign rd_data = q.bytes[rd_addr];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_protect;
		ce && host_wr.en && !host_ok && !factory_wr.en && (host_wr.addr < `MSI_DIAG_BASE)
		|=> q.bytes[$past(host_wr.addr)] == $past(rd_data_at_host);
	endproperty
	a_protect: assert property (p_protect) else $error("protected byte changed"); // RULE_07

	property p_user_write;
		ce && host_wr.en && host_ok |=> q.bytes[$past(host_wr.addr)] == $past(host_wr.data);
	endproperty
	a_user_write: assert property (p_user_write) else $error("host write lost"); // RULE_07

	property p_diag;
		ce |=> q.bytes[`MSI_DIAG_BASE] == $past(diag.temp[15:8])
			&& q.bytes[`MSI_DIAG_BASE + 8'h09] == $past(diag.rx_pwr[7:0]);
	endproperty
	a_diag: assert property (p_diag) else $error("reading not copied"); // RULE_11

	property p_factory;
		ce && factory_wr.en && !host_wr.en && (factory_wr.addr < `MSI_DIAG_BASE)
		|=> q.bytes[$past(factory_wr.addr)] == $past(factory_wr.data);
	endproperty
	a_factory: assert property (p_factory) else $error("factory load lost"); // RULE_12

	// old content of the byte the host aims at, for the protection check
	assign rd_data_at_host = q.bytes[host_wr.addr];

endmodule // msi_mem

`default_nettype wire

// [src/msi_top.sv]
// Functional notes
// RULE_01: transmitter on only while shutdown pin low
// RULE_02: fault output released high on laser fault
// RULE_03: loss output released high on low power
// RULE_04: presence line always pulled to ground
// RULE_05: one line is clock, other is data
// RULE_06: host alone drives the serial clock
// RULE_07: sample on clock rise; protected bytes kept
// RULE_08: driven data changes on clock fall
// RULE_09: data bidirectional; start and stop recognised
// RULE_10: byte words, single or auto-incrementing access
// RULE_11: five converter readings served from memory
// RULE_12: calibration and thresholds preloaded, served stored
// RULE_13: external calibration means raw values reported
// RULE_14: answer only bus address 1010001 plus direction
// RULE_15: acknowledge address and writes; host acks reads
`timescale 1ns/1ns
`default_nettype none
`include "msi_cfg.svh"

module msi_top (
	input  wire logic                  clk,                    // system clock, 20 MHz
	input  wire logic                  rst,                    // async reset, active high
	input  wire logic                  ce,                     // clock enable
	input  wire logic                  serial_id_clock,        // serial clock pin
	input  wire logic                  serial_id_data_in,      // serial data pin level
	output logic                       serial_id_data_out,     // serial data drive value
	output logic                       serial_id_data_oe,      // serial data drive enable
	output logic                       presence_tie_out,       // presence drive value
	output logic                       presence_tie_oe,        // presence drive enable
	input  wire logic                  tx_disable,             // shutdown pin, high or open
	output logic                       tx_enable,              // optical transmitter on
	input  wire logic                  laser_fault_in,         // laser monitor fault level
	output logic                       laser_fault_out,        // fault pin drive value
	output logic                       laser_fault_oe,         // fault pin drive enable
	input  wire logic                  rx_power_low,           // receive power below floor
	output logic                       optical_input_lost_out, // loss pin drive value
	output logic                       optical_input_lost_oe,  // loss pin drive enable
	input  wire msi_pkg::msi_diag_type diag,                   // raw converter readings
	input  wire msi_pkg::msi_wr_type   factory_wr              // manufacture load port
);
	import msi_pkg::*;

	msi_top_state_type q;         // registered state
	msi_top_state_type d;         // next state
	msi_wr_type        host_wr;   // write toward memory
	logic [7:0]        rd_data;   // byte at pointer
	logic              scl_rise;  // clock rising edge seen
	logic              scl_fall;  // clock falling edge seen
	logic              start_det; // start condition seen
	logic              stop_det;  // stop condition seen
	logic              addr_done; // address byte complete at a fall
	logic              addr_hit;  // address byte matches ours
	logic              wr_done;   // write data byte complete at a fall

	// edge and condition detection on synchronised copies only
	always_comb begin
		scl_rise  = q.scl_s2 && !q.scl_s3; // RULE_06
		scl_fall  = !q.scl_s2 && q.scl_s3;
		// data falling while clock high frames a start
		start_det = q.scl_s2 && q.scl_s3 && !q.sda_s2 && q.sda_s3; // RULE_09
		// data rising while clock high frames a stop
		stop_det  = q.scl_s2 && q.scl_s3 && q.sda_s2 && !q.sda_s3; // RULE_09
		addr_done = scl_fall && !start_det && !stop_det
			&& (q.state == S_ADDR) && (q.cnt == `MSI_BYTE_BITS);
		addr_hit  = q.shift[7:1] == `MSI_DEV_ADDR; // RULE_14
		wr_done   = scl_fall && !start_det && !stop_det
			&& (q.state == S_WDATA) && (q.cnt == `MSI_BYTE_BITS);
	end

	// next state of the whole block
	always_comb begin
		d       = q;
		host_wr = '0;
		// two-stage synchronisers for pins
		d.scl_s1 = serial_id_clock; // RULE_05
		d.scl_s2 = q.scl_s1;
		d.scl_s3 = q.scl_s2;
		d.sda_s1 = serial_id_data_in; // RULE_05
		d.sda_s2 = q.sda_s1;
		d.sda_s3 = q.sda_s2;
		d.txd_s1 = tx_disable;
		d.txd_s2 = q.txd_s1;
		// status lines
		d.tx_on  = !q.txd_s2; // RULE_01
		d.fault  = laser_fault_in; // RULE_02
		d.optical_input_lost    = rx_power_low; // RULE_03

		// serial protocol
		if (start_det) begin
			// start or repeated start: fresh address byte
			d.state  = S_ADDR; // RULE_09
			d.cnt    = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop_det) begin
			// stop ends any transfer
			d.state  = S_IDLE; // RULE_09
			d.sda_oe = 1'b0;
		end else begin
			case (q.state)
				S_ADDR, S_WORD, S_WDATA: begin
					if (scl_rise && (q.cnt < `MSI_BYTE_BITS)) begin
						// shift in on the rising edge
						d.shift = {q.shift[6:0], q.sda_s2}; // RULE_07
						d.cnt   = q.cnt + 4'h1;
					end else if (scl_fall && (q.cnt == `MSI_BYTE_BITS)) begin
						d.cnt = 4'h0;
						if (q.state == S_ADDR) begin
							if (addr_hit) begin
								// acknowledge our address
								d.sda_oe = 1'b1; // RULE_15
								d.state  = S_ACK;
								d.after  = q.shift[0] ? S_RDATA : S_WORD;
							end else begin
								// another device: stay off the bus
								d.state = S_IDLE; // RULE_14
							end
						end else if (q.state == S_WORD) begin
							// word address sets the pointer
							d.ptr    = q.shift; // RULE_10
							d.sda_oe = 1'b1; // RULE_15
							d.state  = S_ACK;
							d.after  = S_WDATA;
						end else begin
							// data byte to memory, pointer moves on
							host_wr.en   = 1'b1; // RULE_07
							host_wr.addr = q.ptr;
							host_wr.data = q.shift;
							d.ptr        = q.ptr + 8'h01; // RULE_10
							d.sda_oe     = 1'b1; // RULE_15
							d.state      = S_ACK;
							d.after      = S_WDATA;
						end
					end
				end
				S_ACK: begin
					// acknowledge clock ends at the next fall
					if (scl_fall) begin
						if (q.after == S_RDATA) begin
							// first read byte, msb out at once
							d.shift  = rd_data; // RULE_10
							d.sda_oe = !rd_data[7]; // RULE_08
							d.ptr    = q.ptr + 8'h01; // RULE_10
							d.cnt    = 4'h1;
							d.state  = S_RDATA;
						end else begin
							d.sda_oe = 1'b0;
							d.cnt    = 4'h0;
							d.state  = q.after;
						end
					end
				end
				S_RDATA: begin
					// drive the next bit on each fall
					if (scl_fall) begin
						if (q.cnt == `MSI_BYTE_BITS) begin
							d.sda_oe = 1'b0; // RULE_08
							d.cnt    = 4'h0;
							d.state  = S_RACK;
						end else begin
							d.shift  = {q.shift[6:0], 1'b0};
							d.sda_oe = !q.shift[6]; // RULE_08
							d.cnt    = q.cnt + 4'h1;
						end
					end
				end
				S_RACK: begin
					// host acknowledge sampled on the rise
					if (scl_rise) begin
						d.state = q.sda_s2 ? S_IDLE : S_RNEXT; // RULE_15
					end
				end
				S_RNEXT: begin
					// sequential read: next byte from the advanced pointer
					if (scl_fall) begin
						d.shift  = rd_data; // RULE_10
						d.sda_oe = !rd_data[7]; // RULE_08
						d.ptr    = q.ptr + 8'h01; // RULE_10
						d.cnt    = 4'h1;
						d.state  = S_RDATA;
					end
				end
				default: begin
					// idle: wait for a start
					d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// state registers, frozen while ce is low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q        <= '0;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.scl_s3 <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_s3 <= 1'b1;
			q.txd_s1 <= 1'b1;
			q.txd_s2 <= 1'b1;
			q.state  <= S_IDLE;
			q.after  <= S_IDLE;
		end else if (ce) begin
			q <= d;
		end
	end

	// byte storage and live readings
	msi_mem u_mem (
		.clk        (clk),
		.rst        (rst),
		.ce         (ce),
		.host_wr    (host_wr),
		.factory_wr (factory_wr),
		.diag       (diag),
		.rd_addr    (q.ptr),
		.rd_data    (rd_data)
	);

	// pins: open drain outputs only ever pull low
	assign serial_id_data_out     = 1'b0;
	assign serial_id_data_oe      = q.sda_oe;
	assign presence_tie_out       = 1'b0; // RULE_04
	assign presence_tie_oe        = 1'b1; // RULE_04
	assign tx_enable              = q.tx_on;
	assign laser_fault_out        = 1'b0;
	assign laser_fault_oe         = !q.fault; // RULE_02
	assign optical_input_lost_out = 1'b0;
	assign optical_input_lost_oe  = !q.optical_input_lost; // RULE_03

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	property p_tx_off;
		ce && q.txd_s2 |=> !tx_enable;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmitter on while disabled"); // RULE_01

	property p_fault;
		ce && laser_fault_in |=> !laser_fault_oe && !laser_fault_out;
	endproperty
	a_fault: assert property (p_fault) else $error("fault pin not released"); // RULE_02

	property p_los;
		ce && !rx_power_low |=> optical_input_lost_oe && !optical_input_lost_out;
	endproperty
	a_los: assert property (p_los) else $error("loss pin not held low"); // RULE_03

	property p_presence;
		presence_tie_oe && !presence_tie_out;
	endproperty
	a_presence: assert property (p_presence) else $error("presence not grounded"); // RULE_04

	property p_start;
		ce && start_det |=> q.state == S_ADDR && q.cnt == 4'h0 && !serial_id_data_oe;
	endproperty
	a_start: assert property (p_start) else $error("start not recognised"); // RULE_09

	property p_sample;
		ce && scl_rise && !start_det && !stop_det && q.state == S_ADDR && q.cnt < 4'h8
		|=> q.shift[0] == $past(q.sda_s2) && q.cnt == $past(q.cnt) + 4'h1;
	endproperty
	a_sample: assert property (p_sample) else $error("bit not sampled on rise"); // RULE_07

	property p_mismatch;
		ce && addr_done && !addr_hit |=> q.state == S_IDLE && !serial_id_data_oe;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign address answered"); // RULE_14

	property p_ack;
		ce && addr_done && addr_hit |=> serial_id_data_oe && q.state == S_ACK;
	endproperty
	a_ack: assert property (p_ack) else $error("address not acknowledged"); // RULE_15

	property p_change_on_fall;
		ce && !scl_fall && !start_det && !stop_det |=> $stable(serial_id_data_oe);
	endproperty
	a_change_on_fall: assert property (p_change_on_fall) else $error("data moved off fall"); // RULE_08

	property p_ptr;
		ce && wr_done |=> q.ptr == $past(q.ptr) + 8'h01 && q.state == S_ACK;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer did not advance"); // RULE_10

	property p_tx_on;
		ce && !q.txd_s2 |=> tx_enable;
	endproperty
	a_tx_on: assert property (p_tx_on) else $error("transmitter off while enabled"); // RULE_01

	property p_los_set;
		ce && rx_power_low |=> !optical_input_lost_oe;
	endproperty
	a_los_set: assert property (p_los_set) else $error("loss pin not released"); // RULE_03

	property p_nack;
		ce && q.state == S_RACK && scl_rise && q.sda_s2 |=> q.state == S_IDLE;
	endproperty
	a_nack: assert property (p_nack) else $error("read went on after host nack"); // RULE_15

	property p_read_release;
		ce && q.state == S_RDATA && scl_fall && q.cnt == `MSI_BYTE_BITS
		|=> !serial_id_data_oe && q.state == S_RACK;
	endproperty
	a_read_release: assert property (p_read_release) else $error("data not released"); // RULE_08

endmodule // msi_top

`default_nettype wire

// [bench/msi_host.sv]
`timescale 1ns/1ns
`default_nettype none

// host board controller: master of the serial id link
module msi_host (
	input  wire logic clk,      // bench clock, paces the link
	input  wire logic wire_lvl, // resolved data wire level
	output var  logic scl,      // serial clock, host only
	output var  logic pull      // high while host pulls data low
);
	// idle: both lines left to the pull-ups
	initial begin
		scl  = 1'b1;
		pull = 1'b0;
	end

	// one bit slot of eight clocks, data moved only while clock low
	task automatic bitx(input logic b, output logic r);
		@(posedge clk);
		pull <= ~b;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (2) @(posedge clk);
		r = wire_lvl;
		@(posedge clk);
		scl <= 1'b0;
	endtask

	// start or repeated start: data falls while clock high
	task automatic start();
		@(posedge clk);
		pull <= 1'b0;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		pull <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b0;
	endtask

	// stop: data rises while clock high, lines then stand idle
	task automatic stop();
		@(posedge clk);
		pull <= 1'b1;
		repeat (4) @(posedge clk);
		scl <= 1'b1;
		repeat (4) @(posedge clk);
		pull <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// send a byte msb first, then sample the acknowledge slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], r);
		end
		bitx(1'b1, r);
		ack = ~r;
	endtask

	// take a byte msb first; acknowledge unless it is the last
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			d[i] = r;
		end
		bitx(last, r);
	endtask
endmodule // msi_host

`default_nettype wire

// [bench/msi_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module msi_top_tb;
	import msi_pkg::*;

	logic         clk;        // 20 MHz bench clock
	logic         rst;        // async reset
	logic         ce;         // clock enable, on except for one hold check
	logic         tx_dis;     // shutdown pin
	logic         lf_in;      // laser monitor fault
	logic         rx_low;     // receive power low
	msi_diag_type diag;       // raw readings
	msi_wr_type   fwr;        // manufacture load
	logic         scl;        // link clock from host
	logic         pull;       // host pulls data low
	logic         sda_out;    // device data value
	logic         sda_oe;     // device data enable
	logic         pres_out;   // presence value
	logic         pres_oe;    // presence enable
	logic         tx_en;      // transmitter on
	logic         lf_out;     // fault pin value
	logic         lf_oe;      // fault pin enable
	logic         los_out;    // loss pin value
	logic         los_oe;     // loss pin enable
	wire logic    sda;        // resolved data wire, pulled up
	logic         scl_q;      // link clock one edge ago
	logic         oe_q;       // data enable one edge ago
	logic [95:0]  rnd;        // random readings
	int           fails;      // mismatch count
	int           num_checks; // comparison count
	int           mem [256];  // reference memory model

	assign sda = ~(pull | (sda_oe & ~sda_out));

	// free running clock
	initial clk = 1'b0;
	always #25 clk = ~clk;

	msi_top uut (.clk(clk), .rst(rst), .ce(ce), .serial_id_clock(scl),
		.serial_id_data_in(sda), .serial_id_data_out(sda_out),
		.serial_id_data_oe(sda_oe), .presence_tie_out(pres_out),
		.presence_tie_oe(pres_oe), .tx_disable(tx_dis), .tx_enable(tx_en),
		.laser_fault_in(lf_in), .laser_fault_out(lf_out), .laser_fault_oe(lf_oe),
		.rx_power_low(rx_low), .optical_input_lost_out(los_out),
		.optical_input_lost_oe(los_oe), .diag(diag), .factory_wr(fwr));

	msi_host host (.clk(clk), .wire_lvl(sda), .scl(scl), .pull(pull));

	// compare one flag
	task automatic chk_bit(input logic e, input logic g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// compare one byte
	task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// counts and verdict
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// manufacture load of one byte
	task automatic fload(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		fwr <= '{en: 1'b1, addr: a, data: d};
		mem[a] = d;
	endtask

	// host write of n bytes from address a
	task automatic hwrite(input logic [7:0] a, input int n, input logic [7:0] d);
		logic       ack;
		logic [7:0] p;
		p = a;
		host.start();
		host.wbyte(8'hA2, ack);
		chk_bit(1'b1, ack);
		host.wbyte(a, ack);
		chk_bit(1'b1, ack);
		for (int i = 0; i < n; i++) begin
			host.wbyte(d + 8'(i), ack);
			chk_bit(1'b1, ack);
			if (p >= 8'h80 && p <= 8'hF7) mem[p] = d + 8'(i);
			p = p + 8'h01;
		end
		host.stop();
	endtask

	// random read of n bytes from address a
	task automatic hread(input logic [7:0] a, input int n);
		logic       ack;
		logic [7:0] d;
		logic [7:0] p;
		p = a;
		host.start();
		host.wbyte(8'hA2, ack);
		chk_bit(1'b1, ack);
		host.wbyte(a, ack);
		chk_bit(1'b1, ack);
		host.start();
		host.wbyte(8'hA3, ack);
		chk_bit(1'b1, ack);
		for (int i = 0; i < n; i++) begin
			host.rbyte(i == n - 1, d);
			chk_byte(8'(mem[p]), d);
			p = p + 8'h01;
		end
		host.stop();
	endtask

	// driven data must hold while the link clock is high
	always @(posedge clk) begin
		if (scl_q && scl) chk_bit(oe_q, sda_oe);
		scl_q <= scl;
		oe_q  <= sda_oe;
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		end_of_test();
	end

	// main sequence
	initial begin
		rst    = 1'b1;
		ce     = 1'b1;
		tx_dis = 1'b1;
		lf_in  = 1'b0;
		rx_low = 1'b0;
		diag   = '0;
		fwr    = '0;
		void'($urandom(9374));
		for (int i = 0; i < 256; i++) mem[i] = 0;
		repeat (4) @(posedge clk);
		#1;
		chk_bit(1'b0, tx_en);
		chk_bit(1'b1, pres_oe);
		chk_bit(1'b0, pres_out);
		@(posedge clk);
		rst <= 1'b0;
		// status pins follow their causes
		repeat (24) begin
			@(posedge clk);
			tx_dis <= 1'($urandom);
			lf_in  <= 1'($urandom);
			rx_low <= 1'($urandom);
			repeat (5) @(posedge clk);
			#1;
			chk_bit(~tx_dis, tx_en);
			chk_bit(~lf_in, lf_oe);
			chk_bit(1'b0, lf_out);
			chk_bit(~rx_low, los_oe);
			chk_bit(1'b0, los_out);
			chk_bit(1'b1, pres_oe);
			chk_bit(1'b0, sda_out);
		end
		// clock enable low: transmitter and fault pins hold their values
		@(posedge clk);
		ce     <= 1'b0;
		tx_dis <= ~tx_dis;
		lf_in  <= ~lf_in;
		repeat (5) @(posedge clk);
		#1;
		chk_bit(tx_dis, tx_en);
		chk_bit(lf_in, lf_oe);
		@(posedge clk);
		ce <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk_bit(~tx_dis, tx_en);
		chk_bit(~lf_in, lf_oe);
		// live readings, high byte first
		rnd = {$urandom, $urandom, $urandom};
		@(posedge clk);
		diag <= rnd[79:0];
		for (int i = 0; i < 10; i++) mem[96 + i] = rnd[79 - 8 * i -: 8];
		// calibration constants and one protected byte
		for (int i = 56; i < 96; i++) fload(8'(i), 8'($urandom));
		fload(8'hF8, 8'h5A);
		@(posedge clk);
		fwr.en <= 1'b0;
		repeat (4) @(posedge clk);
		hwrite(8'h80, 3, 8'hC1);
		hwrite(8'hF6, 3, 8'h71);
		hwrite(8'h40, 1, 8'hEE);
		hread(8'h38, 50);
		hread(8'h7E, 4);
		hread(8'hF5, 5);
		hread(8'hFE, 3);
		repeat (6) begin
			rnd[7:0] = 8'h80 + 8'($urandom_range(8'h77));
			hwrite(rnd[7:0], 1, 8'($urandom));
			hread(rnd[7:0], 2);
		end
		// foreign bus address is left unanswered
		host.start();
		host.wbyte(8'hA0, rnd[0]);
		chk_bit(1'b0, rnd[0]);
		host.wbyte(8'h80, rnd[0]);
		host.stop();
		hread(8'h80, 2);
		end_of_test();
	end
endmodule // msi_top_tb

`default_nettype wire
